// >>> rtl/strobe_bank_device.sv
// Purpose: Startup mode and configuration bank switch sequencer of the receiver
// Assumes: Host keeps its own obligations on the link
// Notes: Oscillator enable and receiver enable are taken from bank A
//
// The AXI4-Lite slave port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`include "bank_switch_consts.svh"
module strobe_bank_device #(
  parameter int TICK_CYCLES = `TICK_CYCLES
) (
  input wire logic aclk, // 40 MHz clock
  input wire logic aresetn, // Synchronous reset, active low
  strobe_link_if.dev link, // Pins from host
  input wire logic message_active, // Message reception in progress
  output logic receiver_on, // Receiver powered in an on state
  output logic bank_a_on, // On state uses bank A
  output logic [1:0] mode // Current operating mode
);
  generate
    // Tick divider is 16 bits wide
    if (TICK_CYCLES < 1 || TICK_CYCLES > 65536) begin : g_bad_tick
      $error("TICK_CYCLES must be 1 to 65536");
    end
  endgenerate

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [3:0] pin_s1_r;
  logic [3:0] pin_s2_r;
  logic wake_drv_s, wake_oe_s, cfg_n_s, ser_n_s;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_s1_r <= 4'hc;
      pin_s2_r <= 4'hc;
    end else begin
      pin_s1_r <= {link.config_select_n, link.serial_port_enable_n, link.wake_oe, link.wake_drv};
      pin_s2_r <= pin_s1_r;
    end
  end
  assign {cfg_n_s, ser_n_s, wake_oe_s, wake_drv_s} = pin_s2_r;

  // ----------------------------------------
  // Registers and decode
  // ----------------------------------------
  logic [7:0] bank_r [`NUM_REGS];
  logic [7:0] bank_nxt [`NUM_REGS];
  logic status_r, status_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic rvalid_r, rvalid_nxt;
  bank_switch_pkg::mode_t mode_r, mode_nxt;
  bank_switch_pkg::seq_t seq_r, seq_nxt;
  logic on_r, bank_a_r;
  logic [15:0] div_r, div_nxt;
  logic sched_on_r, sched_on_nxt;
  logic [3:0] sched_cnt_r, sched_cnt_nxt;
  logic pin_prev_r;

  function automatic logic [2:0] bank_base(input logic use_a);
    bank_base = use_a ? 3'h0 : `BANK_B_BASE;
  endfunction : bank_base

  function automatic logic [7:0] reset_val(input int idx);
    case (idx % 4)
      0: reset_val = `CFG_RESET;
      1: reset_val = `CMD_RESET;
      2: reset_val = `TIME_RESET;
      default: reset_val = 8'h00;
    endcase
  endfunction : reset_val

  logic en_a, en_b, dual, osc_en, rx_en, wake_high, wake_low_drv, tick, on_req;
  logic [3:0] limit;
  assign en_a = bank_r[`REG_CMD][`CMD_BANKEN_BIT];
  assign en_b = bank_r[`BANK_B_BASE + `REG_CMD][`CMD_BANKEN_BIT];
  assign dual = en_a & en_b;
  assign osc_en = bank_r[`REG_CFG][`CFG_OSC_BIT];
  assign rx_en = bank_r[`REG_CFG][`CFG_RXEN_BIT];
  assign wake_high = wake_oe_s & wake_drv_s;
  assign wake_low_drv = wake_oe_s & ~wake_drv_s;
  assign tick = (div_r == 16'(TICK_CYCLES - 1));
  // on time from status bank, off time from bank A
  assign limit = sched_on_r ? bank_r[bank_base(status_r) + `REG_TIME][`TIME_ON_LSB +: 4]
                            : {1'b0, bank_r[`REG_TIME][`TIME_OFF_LSB +: 3]};
  // pin rules when driven, oscillator otherwise
  assign on_req = osc_en ? (wake_oe_s ? wake_drv_s : sched_on_r) : wake_high;

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  always_comb begin
    bank_nxt = bank_r;
    status_nxt = status_r;
    mode_nxt = mode_r;
    seq_nxt = seq_r;
    rdata_nxt = rdata_r;
    rvalid_nxt = 1'b0;
    div_nxt = tick ? 16'h0000 : div_r + 16'h0001;
    sched_on_nxt = sched_on_r;
    sched_cnt_nxt = sched_cnt_r;
    case (mode_r)
      bank_switch_pkg::MODE_STANDBY: begin
        // select low with wake high enters configuration
        if (!cfg_n_s && wake_high) begin
          mode_nxt = bank_switch_pkg::MODE_CONFIG;
        end else if (wake_high) begin
          mode_nxt = bank_switch_pkg::MODE_RECEIVE;
        end
      end
      bank_switch_pkg::MODE_CONFIG: begin
        if (cfg_n_s) begin
          mode_nxt = rx_en ? bank_switch_pkg::MODE_RECEIVE : bank_switch_pkg::MODE_STANDBY;
          // selection applies on exit, dual starts at A
          status_nxt = dual | ~en_b;
          sched_on_nxt = 1'b0;
          sched_cnt_nxt = 4'h0;
        end
      end
      bank_switch_pkg::MODE_RECEIVE: begin
        if (!cfg_n_s && wake_high) begin
          mode_nxt = bank_switch_pkg::MODE_CONFIG;
        end else if (!rx_en && !wake_oe_s && !osc_en) begin
          mode_nxt = bank_switch_pkg::MODE_STANDBY;
        end
      end
      default: mode_nxt = bank_switch_pkg::MODE_STANDBY;
    endcase
    // serial access in configuration mode only
    if (mode_r == bank_switch_pkg::MODE_CONFIG && !ser_n_s && link.acc_valid) begin
      rvalid_nxt = 1'b1;
      rdata_nxt = 8'h00;
      if (!link.acc_addr[4] && !link.acc_addr[3]) begin
        if (link.acc_write) begin
          bank_nxt[link.acc_addr[2:0]] = link.acc_wdata;
          bank_nxt[link.acc_addr[2:0]][`CMD_STATUS_BIT] =
            (link.acc_addr[1:0] == 2'(`REG_CMD)) ? 1'b0 : link.acc_wdata[`CMD_STATUS_BIT];
        end else begin
          rdata_nxt = bank_r[link.acc_addr[2:0]];
          if (link.acc_addr[1:0] == 2'(`REG_CMD)) begin
            rdata_nxt[`CMD_STATUS_BIT] = status_r;
          end
        end
      end
    end
    // automatic sequencing only in receive mode
    if (mode_r == bank_switch_pkg::MODE_RECEIVE) begin
      // schedule runs on regardless of actual state
      if (osc_en && tick) begin
        if (sched_cnt_r == limit) begin
          sched_cnt_nxt = 4'h0;
          sched_on_nxt = ~sched_on_r;
          // toggle at on end unless forced high
          if (sched_on_r && dual && !wake_high) begin
            status_nxt = ~status_r;
          end
        end else begin
          sched_cnt_nxt = sched_cnt_r + 4'h1;
        end
      end
      if (!osc_en && dual && pin_prev_r && !wake_high) begin
        status_nxt = ~status_r;
      end
      if (message_active && seq_r != bank_switch_pkg::SEQ_OFF) begin
        seq_nxt = seq_r;
      end else if (on_req) begin
        seq_nxt = status_r ? bank_switch_pkg::SEQ_ON_A : bank_switch_pkg::SEQ_ON_B;
      end else begin
        seq_nxt = bank_switch_pkg::SEQ_OFF;
      end
    end else if (mode_r == bank_switch_pkg::MODE_STANDBY) begin
      seq_nxt = bank_switch_pkg::SEQ_OFF;
    end
  end

  // ----------------------------------------
  // State registers
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < `NUM_REGS; i++) begin
        bank_r[i] <= reset_val(i);
      end
      status_r <= 1'b1;
      mode_r <= bank_switch_pkg::MODE_STANDBY;
      seq_r <= bank_switch_pkg::SEQ_OFF;
      rdata_r <= 8'h00;
      rvalid_r <= 1'b0;
      div_r <= 16'h0000;
      sched_on_r <= 1'b0;
      sched_cnt_r <= 4'h0;
      pin_prev_r <= 1'b0;
      on_r <= 1'b0;
      bank_a_r <= 1'b0;
    end else begin
      bank_r <= bank_nxt;
      status_r <= status_nxt;
      mode_r <= mode_nxt;
      seq_r <= seq_nxt;
      rdata_r <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
      div_r <= div_nxt;
      sched_on_r <= sched_on_nxt;
      sched_cnt_r <= sched_cnt_nxt;
      pin_prev_r <= wake_high;
      on_r <= (seq_nxt != bank_switch_pkg::SEQ_OFF);
      bank_a_r <= (seq_nxt == bank_switch_pkg::SEQ_ON_A);
    end
  end

  assign link.acc_rdata = rdata_r;
  assign link.acc_rvalid = rvalid_r;
  assign receiver_on = on_r;
  assign bank_a_on = bank_a_r;
  assign mode = mode_r;
endmodule : strobe_bank_device

// >>> rtl/bank_switch_consts.svh
// Purpose: Offsets, fields, reset values and timing counts of the bank switch link
// Assumes: 40 MHz aclk
// Notes: Bank B registers sit at bank A offset plus the bank stride
`ifndef BANK_SWITCH_CONSTS_SVH
`define BANK_SWITCH_CONSTS_SVH

// ----------------------------------------
// Device register map, per bank
// ----------------------------------------
`define REG_CFG 3'h0
`define REG_CMD 3'h1
`define REG_TIME 3'h2
`define BANK_B_BASE 3'h4
`define NUM_REGS 8
`define CFG_OSC_BIT 0
`define CFG_RXEN_BIT 1
`define CMD_STATUS_BIT 0
`define CMD_BANKEN_BIT 1
`define TIME_ON_LSB 0
`define TIME_OFF_LSB 4
`define CFG_RESET 8'h00
`define CMD_RESET 8'h01
`define TIME_RESET 8'h11

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_PERIOD_NS 25
`define TICK_NS 1000
`define TICK_CYCLES ((`TICK_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// ----------------------------------------
// Host AXI4-Lite map
// ----------------------------------------
`define H_PIN_CTRL 4'h0
`define H_ACCESS 4'h4
`define H_STATUS 4'h8
`define PIN_WAKE_DRV_BIT 0
`define PIN_WAKE_OE_BIT 1
`define PIN_CFG_SEL_BIT 2
`define PIN_SER_EN_BIT 3
`define ACC_WDATA_LSB 8
`define ACC_WRITE_BIT 16
`define ST_BUSY_BIT 8
`define AXI_OKAY 2'h0
`define AXI_SLVERR 2'h2
`endif

// >>> rtl/bank_switch_pkg.sv
// Purpose: Types of the device end of the bank switch link
// Assumes: Constants come from bank_switch_consts.svh
// Notes: Encodings written out
package bank_switch_pkg;
  typedef enum logic [1:0] {
    MODE_STANDBY = 2'h0,
    MODE_CONFIG = 2'h1,
    MODE_RECEIVE = 2'h2
  } mode_t;

  typedef enum logic [1:0] {
    SEQ_OFF = 2'h0,
    SEQ_ON_A = 2'h1,
    SEQ_ON_B = 2'h2
  } seq_t;
endpackage : bank_switch_pkg

// >>> rtl/strobe_link_if.sv
// Purpose: Pins between host controller and receiver sequencer
// Assumes: Both ends on aclk
// Notes: Wake pin is three-state; undriven means the internal oscillator rules
`timescale 1ns/1ps
interface strobe_link_if;
  logic wake_drv;
  logic wake_oe;
  logic config_select_n;
  logic serial_port_enable_n;
  logic acc_valid;
  logic acc_write;
  logic [4:0] acc_addr;
  logic [7:0] acc_wdata;
  logic [7:0] acc_rdata;
  logic acc_rvalid;

  modport dev (
    input wake_drv, wake_oe, config_select_n, serial_port_enable_n,
    input acc_valid, acc_write, acc_addr, acc_wdata,
    output acc_rdata, acc_rvalid
  );
  modport host (
    output wake_drv, wake_oe, config_select_n, serial_port_enable_n,
    output acc_valid, acc_write, acc_addr, acc_wdata,
    input acc_rdata, acc_rvalid
  );
endinterface : strobe_link_if

// >>> rtl/strobe_bank_host.sv
// Purpose: Host controller driving the wake pin, select lines and register access
// Assumes: Software sequences wake, configuration and access through AXI4-Lite
// Notes: One register access in flight at a time
`timescale 1ns/1ps
`include "bank_switch_consts.svh"
module strobe_bank_host (
  input wire logic aclk, // 40 MHz clock
  input wire logic aresetn, // Synchronous reset, active low
  input wire logic [3:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Write strobes
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [3:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready, // Read data ready
  strobe_link_if.host link // Pins to device
);
  logic [3:0] pins_r, pins_nxt;
  logic acc_v_r, acc_v_nxt, acc_w_r, acc_w_nxt, busy_r, busy_nxt;
  logic [4:0] acc_a_r, acc_a_nxt;
  logic [7:0] acc_d_r, acc_d_nxt, rd_r, rd_nxt;
  logic aw_h_r, aw_h_nxt, w_h_r, w_h_nxt, bv_r, bv_nxt, rv_r, rv_nxt;
  logic [3:0] awa_r, awa_nxt;
  logic [31:0] wd_r, wd_nxt, rdat_r, rdat_nxt;
  logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;

  // ----------------------------------------
  // Bus slave and link driving
  // ----------------------------------------
  always_comb begin
    pins_nxt = pins_r;
    acc_v_nxt = 1'b0;
    acc_w_nxt = acc_w_r;
    acc_a_nxt = acc_a_r;
    acc_d_nxt = acc_d_r;
    busy_nxt = busy_r;
    rd_nxt = rd_r;
    aw_h_nxt = aw_h_r;
    w_h_nxt = w_h_r;
    awa_nxt = awa_r;
    wd_nxt = wd_r;
    bv_nxt = bv_r;
    bresp_nxt = bresp_r;
    rv_nxt = rv_r;
    rdat_nxt = rdat_r;
    rresp_nxt = rresp_r;
    if (link.acc_rvalid) begin
      busy_nxt = 1'b0;
      rd_nxt = link.acc_rdata;
    end
    if (s_axi_awvalid && !aw_h_r && !bv_r) begin
      aw_h_nxt = 1'b1;
      awa_nxt = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_h_r && !bv_r) begin
      w_h_nxt = 1'b1;
      wd_nxt = s_axi_wdata;
    end
    if (aw_h_r && w_h_r) begin
      aw_h_nxt = 1'b0;
      w_h_nxt = 1'b0;
      bv_nxt = 1'b1;
      bresp_nxt = `AXI_OKAY;
      case (awa_r)
        `H_PIN_CTRL: begin
          if (s_axi_wstrb[0]) begin
            pins_nxt = wd_r[3:0];
          end
        end
        `H_ACCESS: begin
          // register writes only through a launched access
          if (!busy_r) begin
            acc_v_nxt = 1'b1;
            busy_nxt = 1'b1;
            acc_a_nxt = wd_r[4:0];
            acc_d_nxt = wd_r[`ACC_WDATA_LSB +: 8];
            acc_w_nxt = wd_r[`ACC_WRITE_BIT];
          end
        end
        `H_STATUS: bresp_nxt = `AXI_OKAY;
        default: bresp_nxt = `AXI_SLVERR;
      endcase
    end
    if (bv_r && s_axi_bready) begin
      bv_nxt = 1'b0;
    end
    if (rv_r && s_axi_rready) begin
      rv_nxt = 1'b0;
    end else if (s_axi_arvalid && !rv_r) begin
      rv_nxt = 1'b1;
      rresp_nxt = `AXI_OKAY;
      case (s_axi_araddr)
        `H_PIN_CTRL: rdat_nxt = {28'h0000000, pins_r};
        `H_ACCESS: rdat_nxt = {15'h0000, acc_w_r, acc_d_r, 3'h0, acc_a_r};
        `H_STATUS: rdat_nxt = {23'h000000, busy_r, rd_r};
        default: begin
          rdat_nxt = 32'h00000000;
          rresp_nxt = `AXI_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      // wake released, select lines high after reset
      pins_r <= 4'h0;
      acc_v_r <= 1'b0;
      acc_w_r <= 1'b0;
      acc_a_r <= 5'h00;
      acc_d_r <= 8'h00;
      busy_r <= 1'b0;
      rd_r <= 8'h00;
      aw_h_r <= 1'b0;
      w_h_r <= 1'b0;
      awa_r <= 4'h0;
      wd_r <= 32'h00000000;
      bv_r <= 1'b0;
      bresp_r <= 2'h0;
      rv_r <= 1'b0;
      rdat_r <= 32'h00000000;
      rresp_r <= 2'h0;
    end else begin
      pins_r <= pins_nxt;
      acc_v_r <= acc_v_nxt;
      acc_w_r <= acc_w_nxt;
      acc_a_r <= acc_a_nxt;
      acc_d_r <= acc_d_nxt;
      busy_r <= busy_nxt;
      rd_r <= rd_nxt;
      aw_h_r <= aw_h_nxt;
      w_h_r <= w_h_nxt;
      awa_r <= awa_nxt;
      wd_r <= wd_nxt;
      bv_r <= bv_nxt;
      bresp_r <= bresp_nxt;
      rv_r <= rv_nxt;
      rdat_r <= rdat_nxt;
      rresp_r <= rresp_nxt;
    end
  end

  // Select bits in the register are active high; pins are active low
  assign link.wake_drv = pins_r[`PIN_WAKE_DRV_BIT];
  assign link.wake_oe = pins_r[`PIN_WAKE_OE_BIT];
  assign link.config_select_n = ~pins_r[`PIN_CFG_SEL_BIT];
  assign link.serial_port_enable_n = ~pins_r[`PIN_SER_EN_BIT];
  assign link.acc_valid = acc_v_r;
  assign link.acc_write = acc_w_r;
  assign link.acc_addr = acc_a_r;
  assign link.acc_wdata = acc_d_r;
  assign s_axi_awready = ~aw_h_r & ~bv_r;
  assign s_axi_wready = ~w_h_r & ~bv_r;
  assign s_axi_bvalid = bv_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = ~rv_r;
  assign s_axi_rvalid = rv_r;
  assign s_axi_rdata = rdat_r;
  assign s_axi_rresp = rresp_r;
endmodule : strobe_bank_host

// >>> tb/strobe_bank_checker.sv
// Purpose: Link and output checks of the bank switch pair
// Assumes: One aclk domain, synchronous active-low reset
// Notes: Wake level counts only while the host drives the pin
`timescale 1ns/1ps
module strobe_bank_checker (
  input wire logic aclk, // Clock
  input wire logic aresetn, // Reset, active low
  input wire logic wake_drv, // Wake pin value
  input wire logic wake_oe, // Wake pin driven
  input wire logic config_select_n, // Config select, active low
  input wire logic acc_valid, // Access pulse
  input wire logic [4:0] acc_addr, // Access address
  input wire logic [7:0] acc_rdata, // Access read data
  input wire logic acc_rvalid, // Access answer
  input wire logic message_active, // Message in progress
  input wire logic receiver_on, // On state
  input wire logic bank_a_on, // On state A
  input wire logic [1:0] mode // Operating mode
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // ----------------------------------------
  // Sequences
  // ----------------------------------------
  sequence s_hi;
    wake_oe && wake_drv && config_select_n;
  endsequence
  // Message must be quiet too, since a message holds the on state
  sequence s_lo;
    wake_oe && !wake_drv && !message_active;
  endsequence

  // ----------------------------------------
  // Properties
  // ----------------------------------------
  property p_reset_standby;
    $rose(aresetn) |-> mode == 2'h0 && !receiver_on && !acc_rvalid;
  endproperty
  a_reset_standby: assert property (p_reset_standby)
    else $error("not in standby after reset");
  property p_rvalid_pulse;
    acc_rvalid |=> !acc_rvalid;
  endproperty
  a_rvalid_pulse: assert property (p_rvalid_pulse)
    else $error("access answer longer than one cycle");
  property p_rvalid_cause;
    acc_rvalid |-> $past(acc_valid) && $past(mode) == 2'h1;
  endproperty
  a_rvalid_cause: assert property (p_rvalid_cause)
    else $error("access answer without access in config");
  property p_refused;
    acc_valid && mode != 2'h1 |=> !acc_rvalid;
  endproperty
  a_refused: assert property (p_refused)
    else $error("access answered outside config");
  property p_unmapped;
    acc_rvalid && $past(acc_addr) > 5'h07 |-> acc_rdata == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");
  property p_a_is_on;
    bank_a_on |-> receiver_on;
  endproperty
  a_a_is_on: assert property (p_a_is_on)
    else $error("bank A state while off");
  property p_config_hold;
    (!config_select_n && wake_oe && wake_drv)[*4] |-> mode == 2'h1;
  endproperty
  a_config_hold: assert property (p_config_hold)
    else $error("config mode not held");
  property p_wake_on;
    s_hi[*5] ##0 (mode == 2'h2 && $past(mode, 3) == 2'h2) |-> receiver_on;
  endproperty
  a_wake_on: assert property (p_wake_on)
    else $error("off while wake held high");
  property p_wake_off;
    s_lo[*5] ##0 mode == 2'h2 |-> !receiver_on;
  endproperty
  a_wake_off: assert property (p_wake_off)
    else $error("on while wake held low");
  property p_msg_hold;
    receiver_on && message_active && mode == 2'h2 && config_select_n
      && $past(config_select_n) && $past(config_select_n, 2)
      |=> receiver_on && $stable(bank_a_on);
  endproperty
  a_msg_hold: assert property (p_msg_hold)
    else $error("state left during message");
endmodule : strobe_bank_checker

// >>> tb/testbench.sv
// Purpose: Self-checking bench of host and device joined by the link
// Assumes: Short tick in the device to keep the run brief
// Notes: Responses are compared by a monitor against a queue of notes
`timescale 1ns/1ps
`include "bank_switch_consts.svh"
module testbench;
  typedef struct {bit rd; logic [1:0] resp; logic [31:0] data; logic [31:0] mask;} exp_t;
  localparam int TK = 4;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [3:0] awaddr = 4'h0, araddr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic message_active = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, receiver_on, bank_a_on, ia, prev;
  logic [1:0] bresp, rresp, mode;
  logic [31:0] rdata, r;
  logic [7:0] dv [4] = '{`CFG_RESET, `CMD_RESET, `TIME_RESET, 8'h00};
  int n_mismatch = 0, check_count = 0, len, off, el;
  exp_t exp_q[$];
  exp_t e;
  strobe_link_if link();
  strobe_bank_device #(.TICK_CYCLES(TK)) i_strobe_bank_device (.aclk(aclk),
    .aresetn(aresetn), .link(link), .message_active(message_active),
    .receiver_on(receiver_on), .bank_a_on(bank_a_on), .mode(mode));
  strobe_bank_host i_strobe_bank_host (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .link(link));
  strobe_bank_checker i_strobe_bank_checker (.aclk(aclk), .aresetn(aresetn),
    .wake_drv(link.wake_drv), .wake_oe(link.wake_oe),
    .config_select_n(link.config_select_n), .acc_valid(link.acc_valid),
    .acc_addr(link.acc_addr), .acc_rdata(link.acc_rdata), .acc_rvalid(link.acc_rvalid),
    .message_active(message_active), .receiver_on(receiver_on),
    .bank_a_on(bank_a_on), .mode(mode));
  always #12.5 aclk = ~aclk;

  // ----------------------------------------
  // Checking
  // ----------------------------------------
  task automatic give_verdict();
    if (n_mismatch == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : give_verdict
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    check_count++;
    if (g !== x) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask : chk
  // Registered outputs are settled at the falling edge
  always @(negedge aclk) begin
    if ((bvalid && bready) || (rvalid && rready)) begin
      e = exp_q.pop_front();
      chk(e.rd ? rresp : bresp, e.resp);
      chk(rdata & e.mask, e.data & e.mask);
    end
  end

  // ----------------------------------------
  // Drivers
  // ----------------------------------------
  task automatic xfer(input bit rd, input logic [3:0] a, input logic [31:0] d,
      input logic [1:0] rs, input logic [31:0] m);
    bit ha, hw, hr;
    @(posedge aclk);
    exp_q.push_back('{rd, rs, d, m});
    if (rd) begin
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
    end else begin
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
    end
    do begin
      @(negedge aclk);
      ha = (awvalid && awready) || (arvalid && arready);
      hw = wvalid && wready;
      hr = (bvalid && bready) || (rvalid && rready);
      @(posedge aclk);
      if (ha) begin
        awvalid <= 1'b0;
        arvalid <= 1'b0;
      end
      if (hw) wvalid <= 1'b0;
      if (hr) begin
        bready <= 1'b0;
        rready <= 1'b0;
      end
    // A hung wait is ended by the watchdog only
    end while (!hr);
  endtask : xfer
  // Pin bits: wake value, wake driven, config select, serial enable
  task automatic pins(input logic [3:0] p);
    xfer(1'b0, `H_PIN_CTRL, {28'h0, p}, `AXI_OKAY, 32'h0);
    repeat (6) @(posedge aclk);
  endtask : pins
  task automatic dev(input bit wr, input logic [4:0] a, input logic [7:0] d,
      input logic [7:0] x, input logic [7:0] m);
    xfer(1'b0, `H_ACCESS, {15'h0, wr, d, 3'h0, a}, `AXI_OKAY, 32'h0);
    repeat (3) @(posedge aclk);
    xfer(1'b1, `H_STATUS, {24'h0, x}, `AXI_OKAY, {23'h0, 1'b1, m});
  endtask : dev
  task automatic run(output int off, output int len, output logic a);
    off = 0;
    len = 0;
    while (receiver_on !== 1'b1 && off < 400) begin
      @(negedge aclk);
      off++;
    end
    a = bank_a_on;
    while (receiver_on === 1'b1 && len < 400) begin
      @(negedge aclk);
      len++;
    end
  endtask : run

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    r = $urandom(28654);
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(negedge aclk);
    chk(mode, 32'h0);
    xfer(1'b1, 4'hc, 32'h0, `AXI_SLVERR, 32'hffffffff);
    xfer(1'b0, 4'hc, $urandom, `AXI_SLVERR, 32'h0);
    pins(4'h3);
    chk(mode, 32'h2);
    pins(4'hf);
    chk(mode, 32'h1);
    for (int i = 0; i < 7; i++) if (i % 4 != 3) dev(1'b0, 5'(i), 8'h0, dv[i % 4], 8'hff);
    dev(1'b0, 5'h08 + 5'($urandom_range(23)), 8'h0, 8'h00, 8'hff);
    r = $urandom & 32'h7f;
    dev(1'b1, 5'h06, r[7:0], 8'h0, 8'h0);
    dev(1'b0, 5'h06, 8'h0, r[7:0], 8'h7f);
    dev(1'b1, 5'h01, 8'h00, 8'h0, 8'h0);
    dev(1'b0, 5'h01, 8'h0, 8'h01, 8'h01);
    dev(1'b0, 5'h05, 8'h0, 8'h01, 8'h01);
    dev(1'b1, 5'h00, 8'h02, 8'h0, 8'h0);
    dev(1'b1, 5'h01, 8'h02, 8'h0, 8'h0);
    dev(1'b1, 5'h05, 8'h02, 8'h0, 8'h0);
    pins(4'h2);
    chk(receiver_on, 32'h0);
    for (int k = 0; k < 3; k++) begin
      pins(4'h3);
      chk(bank_a_on, 32'(k != 1));
      message_active <= (k == 1);
      pins(4'h2);
      chk(receiver_on, 32'(k == 1));
      message_active <= 1'b0;
      repeat (3) @(posedge aclk);
      chk(receiver_on, 32'h0);
    end
    pins(4'hf);
    dev(1'b0, 5'h00, 8'h0, 8'h02, 8'hff);
    dev(1'b0, 5'h01, 8'h0, 8'h00, 8'h01);
    pins(4'h2);
    pins(4'h3);
    chk(bank_a_on, 32'h1);
    pins(4'hf);
    dev(1'b1, 5'h02, 8'h21, 8'h0, 8'h0);
    dev(1'b1, 5'h06, 8'h03, 8'h0, 8'h0);
    dev(1'b1, 5'h00, 8'h03, 8'h0, 8'h0);
    pins(4'h0);
    run(off, len, ia);
    for (int k = 0; k < 4; k++) begin
      prev = ia;
      run(off, len, ia);
      el = ia ? 2 * TK : 4 * TK;
      if (k > 0) chk(ia, !prev);
      chk(32'(len > el - TK && len <= el + TK), 32'h1);
      chk(32'(off > 2 * TK && off <= 4 * TK), 32'h1);
    end
    pins(4'h3);
    prev = bank_a_on;
    repeat (40) @(posedge aclk);
    chk({receiver_on, bank_a_on}, {1'b1, prev});
    aresetn <= 1'b0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(negedge aclk);
    chk(mode, 32'h0);
    pins(4'hf);
    dev(1'b0, 5'h02, 8'h0, `TIME_RESET, 8'hff);
    dev(1'b0, 5'h00, 8'h0, `CFG_RESET, 8'hff);
    give_verdict();
  end
  // Whole run needs under a thousand cycles
  initial begin
    #500000;
    n_mismatch++;
    give_verdict();
  end
endmodule : testbench
